// *** rtl/cmf_pkg.sv ***
package cmf_pkg;
	localparam int CLK_MHZ        = 100;
	localparam int CYC_PER_MS     = CLK_MHZ * 1000;
	localparam int CYC_PER_US     = CLK_MHZ;
	localparam int CNT_W          = 28;
	localparam int VALID_MS       = 30;
	localparam int RETRY_MS       = 2000;
	localparam int BLINK_HALF_MS  = 250;
	localparam int PROBE_MS       = 10;
	localparam int PMID_US        = 500;
	localparam int VALID_CYC      = VALID_MS * CYC_PER_MS;
	localparam int RETRY_CYC      = RETRY_MS * CYC_PER_MS;
	localparam int BLINK_CYC      = BLINK_HALF_MS * CYC_PER_MS;
	localparam int PROBE_CYC      = PROBE_MS * CYC_PER_MS;
	localparam int PMID_CYC       = PMID_US * CYC_PER_US;
	localparam int FLOOR_BASE_MV  = 4225;
	localparam int FLOOR_STEP_MV  = 75;

	localparam logic [3:0] REG_FAULT   = 4'h0;
	localparam logic [3:0] REG_CTRL    = 4'h1;
	localparam logic [3:0] REG_FLOOR   = 4'h5;
	localparam logic [3:0] REG_HOSTPIN = 4'h6;
	localparam int CTRL_BOOST_BIT = 0;
	localparam int CTRL_HIZ_BIT   = 1;
	localparam int CTRL_INH_BIT   = 2;
	localparam int FAULT_ALLOW_BIT = 6;
	localparam int FLOOR_FLAG_BIT = 4;
	localparam int HOST_ALLOW_BIT = 0;
	localparam int HOST_POL_BIT   = 1;

	typedef enum logic [2:0]
	{
		FLT_NONE    = 3'h0,
		FLT_OVP     = 3'h1,
		FLT_SLEEP   = 3'h2,
		FLT_POOR    = 3'h3,
		FLT_BAT_OVP = 3'h4,
		FLT_THERMAL = 3'h5,
		FLT_NO_BAT  = 3'h7
	} cmf_fault_t;

	typedef enum logic [1:0]
	{
		STAT_READY = 2'h0,
		STAT_CHG   = 2'h1,
		STAT_DONE  = 2'h2,
		STAT_FAULT = 2'h3
	} cmf_stat_t;

	typedef enum logic [1:0]
	{
		MODE_CHARGE = 2'h0,
		MODE_NOCHG  = 2'h1,
		MODE_BOOST  = 2'h2,
		MODE_HIZ    = 2'h3
	} cmf_mode_t;

	typedef enum logic [2:0]
	{
		ST_VALIDATE = 3'b000,
		ST_CHARGE   = 3'b001,
		ST_PROBE    = 3'b011,
		ST_DONE     = 3'b010,
		ST_NOBAT    = 3'b110,
		ST_RETRY    = 3'b111,
		ST_OVP      = 3'b101
	} cmf_state_t;

	typedef struct packed
	{
		logic vbusAboveMin;
		logic vbusAboveOvp;
		logic vbusOvpClear;
		logic vbusBelowSleep;
		logic vbatOver4v8;
		logic vbatAbove2v;
		logic dieOverheat;
		logic dieCooled;
		logic floorLoopActive;
		logic termDetect;
		logic disablePin;
		logic hostPowerPin;
		logic pmidReady;
		logic vbusAboveTarget;
		logic valleyZero;
	} cmf_sense_t;

	typedef struct packed
	{
		logic      chargeEn;
		logic      inputSwitchOn;
		logic      reverseBlock;
		logic      probeDrainOn;
		logic      inputLimit500;
		logic      hiZ;
		logic      boostEn;
		logic      boostPulseAllow;
		cmf_mode_t opMode;
		logic [12:0] floorMv;
	} cmf_ctl_t;
endpackage

// *** rtl/cmf_ctrl.sv ***
// Overview of operation
// [R1] floor flag in register 5 bit 4 shows the floor loop limits current
// [R2] register 5 bits 2:0 pick floor voltage, 4.225 V plus 75 mV per code
// [R3] overheat suspends charging, writes fault 101 and flags the status pin
// [R4] thermal suspend freezes timers and state; resumes once die has cooled
// [R5] input between minimum and battery plus margin enters sleep, blocks reverse
// [R6] input below minimum while charging stops charge, status 11, fault 011
// [R7] after undervoltage, retry wait of two seconds then restart on recovered input
// [R8] input overvoltage opens input switch, suspends charge, fault 001, status 11
// [R9] overvoltage clears about 200 mV lower; charge resumes after revalidation
// [R10] battery above 4.8 V gives fault 100, status 11 and status pin flag
// [R11] termination stops charge, status 10, probe drain; battery above 2 V gives 000
// [R12] battery below 2 V after probe means absent: no-battery mode, fault 111
// [R13] no-battery keeps charging at 500 mA; leaves on input reconnect or disable pin
// [R14] status pin open idle, low charging when allowed, 2 Hz toggle on any fault
// [R15] register 0 bits 2:0 carry the charge-mode fault code
// [R16] charging only with disable pin, inhibit bit and high-impedance bit all clear
// [R17] operating mode from high-impedance bit, boost request bit and fault state
// [R18] host power pin active level follows the polarity bit
// [R19] allowed active host pin enables boost even in high impedance
// [R20] high-impedance bit overrides the boost request bit
// [R21] burst skip: pulses inhibited above target, allowed below it
// [R22] input must stay valid 30 ms before charging starts
// [R23] boost fault clears boost request, forces high impedance, records fault
// [R24] boost fault when intermediate node not ready 500 us after boost start
// [R25] 2 Hz toggle from a clock divider restarted when a fault appears
// [R26] fault code latched until its cause clears or a newer fault replaces it
`timescale 1ns/1ps
module cmf_ctrl #(
	parameter logic [cmf_pkg::CNT_W-1:0] VALID_CYC = cmf_pkg::CNT_W'(cmf_pkg::VALID_CYC),
	parameter logic [cmf_pkg::CNT_W-1:0] RETRY_CYC = cmf_pkg::CNT_W'(cmf_pkg::RETRY_CYC),
	parameter logic [cmf_pkg::CNT_W-1:0] BLINK_CYC = cmf_pkg::CNT_W'(cmf_pkg::BLINK_CYC),
	parameter logic [cmf_pkg::CNT_W-1:0] PROBE_CYC = cmf_pkg::CNT_W'(cmf_pkg::PROBE_CYC),
	parameter logic [cmf_pkg::CNT_W-1:0] PMID_CYC  = cmf_pkg::CNT_W'(cmf_pkg::PMID_CYC)
)(
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic [3:0]         addr,
	input  wire logic [7:0]         wrData,
	input  wire logic               wrStb,
	input  wire logic               rdStb,
	output logic [7:0]              rdData,
	input  wire cmf_pkg::cmf_sense_t senseIn,
	output cmf_pkg::cmf_ctl_t       ctl,
	output logic                    condPinOut,
	output logic                    condPinOe
);
	import cmf_pkg::*;

	initial
	begin
		if (VALID_CYC == '0 || RETRY_CYC == '0 || BLINK_CYC == '0 || PROBE_CYC == '0 || PMID_CYC == '0)
			$error("cmf_ctrl: cycle counts must be nonzero");
	end

	function automatic logic cntDone(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] lim);
		cntDone = (cnt >= lim - CNT_W'(1));
	endfunction

	cmf_sense_t senseMeta_q;
	cmf_sense_t sense_q;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			senseMeta_q <= '0;
			sense_q     <= '0;
		end
		else
		begin
			senseMeta_q <= senseIn;
			sense_q     <= senseMeta_q;
		end
	end

	cmf_state_t       state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] blinkCnt_q, blinkCnt_d;
	logic [CNT_W-1:0] bstCnt_q, bstCnt_d;
	cmf_fault_t       fault_q, fault_d;
	cmf_stat_t        stat_q, stat_d;
	logic             thermal_q, thermal_d;
	logic             batOvp_q, batOvp_d;
	logic             blink_q, blink_d;
	logic             burst_q, burst_d;
	logic             bstFault_q, bstFault_d;
	logic             boostReq_q, boostReq_d;
	logic             hizReq_q, hizReq_d;
	logic             inhibit_q, inhibit_d;
	logic             statAllow_q, statAllow_d;
	logic             hostAllow_q, hostAllow_d;
	logic             hostPol_q, hostPol_d;
	logic [2:0]       floorSel_q, floorSel_d;
	logic [7:0]       rdData_d;

	logic chargeAllow;
	logic inputValid;
	logic sleepCond;
	logic hostActive;
	logic boostOn;
	logic faultActive;
	logic charging;

	always_comb
	begin
		chargeAllow = !sense_q.disablePin && !inhibit_q && !hizReq_q; // [R16]
		inputValid  = sense_q.vbusAboveMin && !sense_q.vbusAboveOvp;
		sleepCond   = sense_q.vbusAboveMin && sense_q.vbusBelowSleep; // [R5]
		hostActive  = (sense_q.hostPowerPin == hostPol_q); // [R18]
		boostOn     = (hostAllow_q && hostActive) || (!hizReq_q && boostReq_q); // [R19] [R20]
		faultActive = (fault_q != FLT_NONE);
		charging    = (state_q == ST_CHARGE || state_q == ST_NOBAT) && !thermal_q && !batOvp_q && !sleepCond;
	end

	always_comb
	begin
		state_d     = state_q;
		cnt_d       = cnt_q;
		fault_d     = fault_q;
		stat_d      = stat_q;
		thermal_d   = thermal_q;
		batOvp_d    = batOvp_q;
		burst_d     = burst_q;
		bstCnt_d    = bstCnt_q;
		bstFault_d  = bstFault_q;
		boostReq_d  = boostReq_q;
		hizReq_d    = hizReq_q;
		inhibit_d   = inhibit_q;
		statAllow_d = statAllow_q;
		hostAllow_d = hostAllow_q;
		hostPol_d   = hostPol_q;
		floorSel_d  = floorSel_q;
		rdData_d    = '0;

		if (rdStb)
		begin
			case (addr)
				REG_FAULT:   rdData_d = {1'b0, statAllow_q, stat_q, 1'b0, fault_q}; // [R15]
				REG_CTRL:    rdData_d = {5'h0, inhibit_q, hizReq_q, boostReq_q};
				REG_FLOOR:   rdData_d = {3'h0, sense_q.floorLoopActive, 1'b0, floorSel_q}; // [R1]
				REG_HOSTPIN: rdData_d = {6'h0, hostPol_q, hostAllow_q};
				default:     rdData_d = '0;
			endcase
		end
		if (wrStb)
		begin
			case (addr)
				REG_FAULT:   statAllow_d = wrData[FAULT_ALLOW_BIT];
				REG_CTRL:
				begin
					boostReq_d = wrData[CTRL_BOOST_BIT];
					hizReq_d   = wrData[CTRL_HIZ_BIT];
					inhibit_d  = wrData[CTRL_INH_BIT];
					bstFault_d = 1'b0;
				end
				REG_FLOOR:   floorSel_d = wrData[2:0]; // [R2]
				REG_HOSTPIN:
				begin
					hostAllow_d = wrData[HOST_ALLOW_BIT];
					hostPol_d   = wrData[HOST_POL_BIT];
				end
				default:     ;
			endcase
		end

		// boost start-up watchdog on the intermediate node
		if (!boostOn || sense_q.pmidReady || bstFault_q)
			bstCnt_d = '0;
		else if (cntDone(bstCnt_q, PMID_CYC)) // [R24]
		begin
			bstCnt_d   = '0;
			bstFault_d = 1'b1; // [R23]
			boostReq_d = 1'b0; // [R23]
			fault_d    = FLT_SLEEP; // [R23]
		end
		else
			bstCnt_d = bstCnt_q + CNT_W'(1);

		if (!boostOn)
			burst_d = 1'b0;
		else if (sense_q.vbusAboveTarget && sense_q.valleyZero)
			burst_d = 1'b1; // [R21]

		if (sense_q.vbatOver4v8 && !batOvp_q)
		begin
			batOvp_d = 1'b1;
			fault_d  = FLT_BAT_OVP; // [R10]
			stat_d   = STAT_FAULT; // [R10]
		end
		else if (!sense_q.vbatOver4v8 && batOvp_q)
		begin
			batOvp_d = 1'b0;
			if (fault_q == FLT_BAT_OVP)
				fault_d = FLT_NONE; // [R26]
		end

		if (thermal_q)
		begin
			if (sense_q.dieCooled && !sense_q.dieOverheat) // [R4]
			begin
				thermal_d = 1'b0;
				if (fault_q == FLT_THERMAL)
					fault_d = FLT_NONE; // [R26]
			end
		end
		else if (sense_q.dieOverheat)
		begin
			thermal_d = 1'b1; // [R3]
			fault_d   = FLT_THERMAL; // [R3]
			stat_d    = STAT_FAULT;
		end
		else
		begin
			// charge sequence advances only while the die is not suspended [R4]
			case (state_q)
				ST_VALIDATE:
				begin
					stat_d = (stat_q == STAT_FAULT) ? STAT_FAULT : STAT_READY;
					if (!inputValid || !chargeAllow || sleepCond)
						cnt_d = '0;
					else if (cntDone(cnt_q, VALID_CYC)) // [R22]
					begin
						cnt_d   = '0;
						state_d = ST_CHARGE;
						stat_d  = STAT_CHG;
						if (fault_q == FLT_POOR || fault_q == FLT_SLEEP)
							fault_d = FLT_NONE; // [R26]
					end
					else
						cnt_d = cnt_q + CNT_W'(1);
					if (sense_q.vbusAboveOvp)
					begin
						state_d = ST_OVP; // [R8]
						fault_d = FLT_OVP;
						stat_d  = STAT_FAULT;
					end
					else if (sleepCond && fault_q == FLT_NONE)
						fault_d = FLT_SLEEP; // [R5]
				end
				ST_CHARGE, ST_PROBE, ST_DONE, ST_NOBAT:
				begin
					if (sense_q.vbusAboveOvp)
					begin
						state_d = ST_OVP; // [R8]
						fault_d = FLT_OVP; // [R8]
						stat_d  = STAT_FAULT; // [R8]
						cnt_d   = '0;
					end
					else if (!sense_q.vbusAboveMin)
					begin
						cnt_d = '0;
						if (state_q == ST_CHARGE)
						begin
							state_d = ST_RETRY; // [R6]
							fault_d = FLT_POOR; // [R6]
							stat_d  = STAT_FAULT; // [R6]
						end
						else
							state_d = ST_VALIDATE; // [R13]
					end
					else if (sleepCond)
					begin
						state_d = ST_VALIDATE; // [R5]
						fault_d = FLT_SLEEP;
						cnt_d   = '0;
					end
					else if (state_q == ST_NOBAT ? sense_q.disablePin : !chargeAllow) // [R13] [R16]
					begin
						state_d = ST_VALIDATE;
						stat_d  = STAT_READY;
						cnt_d   = '0;
						if (fault_q == FLT_NO_BAT)
							fault_d = FLT_NONE;
					end
					else if (state_q == ST_CHARGE && sense_q.termDetect)
					begin
						state_d = ST_PROBE; // [R11]
						stat_d  = STAT_DONE; // [R11]
						cnt_d   = '0;
					end
					else if (state_q == ST_PROBE)
					begin
						if (cntDone(cnt_q, PROBE_CYC))
						begin
							cnt_d = '0;
							if (sense_q.vbatAbove2v)
							begin
								state_d = ST_DONE;
								fault_d = FLT_NONE; // [R11]
							end
							else
							begin
								state_d = ST_NOBAT; // [R12]
								fault_d = FLT_NO_BAT; // [R12]
							end
						end
						else
							cnt_d = cnt_q + CNT_W'(1);
					end
				end
				ST_RETRY:
				begin
					if (sense_q.vbusAboveOvp)
					begin
						state_d = ST_OVP; // [R8]
						fault_d = FLT_OVP;
						stat_d  = STAT_FAULT;
						cnt_d   = '0;
					end
					else if (!cntDone(cnt_q, RETRY_CYC))
						cnt_d = cnt_q + CNT_W'(1);
					else if (sense_q.vbusAboveMin) // [R7]
					begin
						cnt_d   = '0;
						state_d = ST_VALIDATE;
					end
				end
				ST_OVP:
				begin
					cnt_d = '0;
					if (sense_q.vbusOvpClear) // [R9]
					begin
						state_d = ST_VALIDATE; // [R9]
						stat_d  = STAT_READY;
						if (fault_q == FLT_OVP)
							fault_d = FLT_NONE;
					end
				end
				default:
				begin
					state_d = ST_VALIDATE;
					cnt_d   = '0;
				end
			endcase
		end
	end

	always_comb
	begin
		blinkCnt_d = blinkCnt_q + CNT_W'(1);
		blink_d    = blink_q;
		if (!faultActive || fault_d != fault_q)
		begin
			blinkCnt_d = '0; // [R25]
			blink_d    = 1'b1;
		end
		else if (cntDone(blinkCnt_q, BLINK_CYC)) // [R25]
		begin
			blinkCnt_d = '0;
			blink_d    = !blink_q; // [R14]
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_q     <= ST_VALIDATE;
			cnt_q       <= '0;
			blinkCnt_q  <= '0;
			bstCnt_q    <= '0;
			fault_q     <= FLT_NONE;
			stat_q      <= STAT_READY;
			thermal_q   <= 1'b0;
			batOvp_q    <= 1'b0;
			blink_q     <= 1'b0;
			burst_q     <= 1'b0;
			bstFault_q  <= 1'b0;
			boostReq_q  <= 1'b0;
			hizReq_q    <= 1'b0;
			inhibit_q   <= 1'b0;
			statAllow_q <= 1'b1;
			hostAllow_q <= 1'b0;
			hostPol_q   <= 1'b1;
			floorSel_q  <= 3'h0;
			rdData      <= 8'h00;
		end
		else
		begin
			state_q     <= state_d;
			cnt_q       <= cnt_d;
			blinkCnt_q  <= blinkCnt_d;
			bstCnt_q    <= bstCnt_d;
			fault_q     <= fault_d;
			stat_q      <= stat_d;
			thermal_q   <= thermal_d;
			batOvp_q    <= batOvp_d;
			blink_q     <= blink_d;
			burst_q     <= burst_d;
			bstFault_q  <= bstFault_d;
			boostReq_q  <= boostReq_d;
			hizReq_q    <= hizReq_d;
			inhibit_q   <= inhibit_d;
			statAllow_q <= statAllow_d;
			hostAllow_q <= hostAllow_d;
			hostPol_q   <= hostPol_d;
			floorSel_q  <= floorSel_d;
			rdData      <= rdData_d;
		end
	end

	always_comb
	begin
		ctl.chargeEn        = charging && chargeAllow && !bstFault_q && !boostOn; // [R16]
		ctl.inputSwitchOn   = (state_q != ST_OVP); // [R8]
		ctl.reverseBlock    = sleepCond; // [R5]
		ctl.probeDrainOn    = (state_q == ST_PROBE) && !thermal_q; // [R11]
		ctl.inputLimit500   = (state_q == ST_NOBAT); // [R13]
		ctl.hiZ             = !chargeAllow || bstFault_q; // [R16] [R23]
		ctl.boostEn         = boostOn && !bstFault_q;
		// pulses only while boost runs; the skip entry condition inhibits at once
		ctl.boostPulseAllow = ctl.boostEn && !(sense_q.vbusAboveTarget && (burst_q || sense_q.valleyZero)); // [R21]
		ctl.floorMv         = 13'(FLOOR_BASE_MV) + 13'(FLOOR_STEP_MV) * {10'h0, floorSel_q}; // [R2]
		if (hizReq_q)
			ctl.opMode = MODE_HIZ; // [R17]
		else if (faultActive)
			ctl.opMode = MODE_NOCHG;
		else if (boostReq_q)
			ctl.opMode = MODE_BOOST;
		else
			ctl.opMode = MODE_CHARGE;
		condPinOut = 1'b0;
		if (faultActive)
			condPinOe = blink_q; // [R14]
		else
			condPinOe = ctl.chargeEn && statAllow_q; // [R14]
	end
endmodule

// *** testbench/cmf_host_pin.sv ***
`timescale 1ns/1ps
module cmf_host_pin (
	input  wire logic condPinOut,
	input  wire logic condPinOe,
	output logic      pinLevel
);
	// board pull-up holds the open-drain line high when released
	assign pinLevel = condPinOe ? condPinOut : 1'b1;
endmodule

// *** testbench/cmf_ctrl_chk.sv ***
`timescale 1ns/1ps
module cmf_ctrl_chk
	import cmf_pkg::*;
(
	input wire logic                 clk,
	input wire logic                 rst,
	input wire logic [3:0]           addr,
	input wire logic                 rdStb,
	input wire logic [7:0]           rdData,
	input wire cmf_pkg::cmf_sense_t  senseIn,
	input wire cmf_pkg::cmf_ctl_t    ctl,
	input wire logic                 condPinOut
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_ovp_held;
		senseIn.vbusAboveOvp [*5];
	endsequence
	sequence s_skip_held;
		(senseIn.vbusAboveTarget && senseIn.valleyZero) [*5];
	endsequence
	a_rd_idle_zero: assert property (!$past(rdStb) |-> rdData == 8'h00)
		else $error("read data not zero outside read slot");
	a_rd_unmapped: assert property (rdStb && addr == 4'h3 |=> rdData == 8'h00)
		else $error("unmapped read not zero");
	a_pin_drive_low: assert property (condPinOut == 1'b0)
		else $error("status pin drives high");
	a_disable_stop: assert property (senseIn.disablePin [*5] |-> !ctl.chargeEn)
		else $error("charging with disable pin set");
	a_ovp_switch_off: assert property (s_ovp_held |-> !ctl.inputSwitchOn && !ctl.chargeEn)
		else $error("input switch on during overvoltage");
	a_floor_range: assert property (ctl.floorMv >= 13'h1081 && ctl.floorMv <= 13'h128E
		&& (ctl.floorMv - 13'h1081) % 13'h004B == 13'h0000)
		else $error("floor voltage off grid");
	a_boost_mode_en: assert property (ctl.opMode == MODE_BOOST |-> ctl.boostEn)
		else $error("boost mode without boost enable");
	a_burst_inhibit: assert property (s_skip_held |-> !ctl.boostPulseAllow)
		else $error("boost pulse allowed above target");
endmodule

// *** testbench/tb_cmf_ctrl.sv ***
`timescale 1ns/1ps
module tb_cmf_ctrl;
	import cmf_pkg::*;
	localparam int VC = 20;
	localparam int RC = 40;
	localparam int BC = 8;
	localparam int PC = 10;
	localparam cmf_sense_t SENSE0 = cmf_sense_t'(15'h1284);
	logic       clk;
	logic       rst;
	logic [3:0] addr;
	logic [7:0] wrData;
	logic       wrStb;
	logic       rdStb;
	logic [7:0] rdData;
	cmf_sense_t sense;
	cmf_ctl_t   ctl;
	logic       condPinOut;
	logic       condPinOe;
	logic       pinLevel;
	int         n_fail;
	int         total_checks;
	cmf_ctrl #(.VALID_CYC(CNT_W'(VC)), .RETRY_CYC(CNT_W'(RC)), .BLINK_CYC(CNT_W'(BC)),
		.PROBE_CYC(CNT_W'(PC)), .PMID_CYC(CNT_W'(15))) uut (.clk(clk), .rst(rst), .addr(addr),
		.wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .senseIn(sense), .ctl(ctl),
		.condPinOut(condPinOut), .condPinOe(condPinOe));
	cmf_host_pin host (.condPinOut(condPinOut), .condPinOe(condPinOe), .pinLevel(pinLevel));
	task end_sim;
		$display("checks %0d errors %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(string nm, logic [15:0] got, logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task w(int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task wr(logic [3:0] a, logic [7:0] d);
		@(posedge clk);
		addr   <= a;
		wrData <= d;
		wrStb  <= 1'b1;
		@(posedge clk);
		wrStb  <= 1'b0;
	endtask
	task rc(logic [3:0] a, logic [7:0] e, logic [7:0] m = 8'hFF);
		@(posedge clk);
		addr  <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1;
		chk("rdData", 16'(rdData & m), 16'(e));
	endtask
	task rst_dut;
		@(posedge clk);
		rst   <= 1'b1;
		sense <= SENSE0;
		repeat (5) @(posedge clk);
		rst   <= 1'b0;
	endtask
	task go_chg;
		rst_dut();
		@(posedge clk) sense.vbusAboveMin <= 1'b1;
		w(VC - 4);
		chk("chargeEn early", 16'(ctl.chargeEn), 16'h0000);
		w(12);
		chk("chargeEn", 16'(ctl.chargeEn), 16'h0001);
	endtask
	task wait_pin(output int n);
		logic o;
		o = condPinOe;
		n = 0;
		while (condPinOe === o && n < 50)
		begin
			@(negedge clk);
			n++;
		end
	endtask
	task t_regs;
		rst_dut();
		rc(4'h0, 8'h40);
		rc(4'h1, 8'h00);
		rc(4'h6, 8'h02);
		wr(4'h3, 8'hFF);
		rc(4'h3, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			wr(4'h5, 8'(i));
			w(2);
			chk("floorMv", 16'(ctl.floorMv), 16'h1081 + 16'h004B * 16'(i));
		end
		@(posedge clk) sense.floorLoopActive <= 1'b1;
		w(5);
		rc(4'h5, 8'h17);
	endtask
	task t_charge;
		go_chg();
		rc(4'h0, 8'h50);
		chk("pin low", 16'(pinLevel), 16'h0000);
		wr(4'h0, 8'h00);
		w(2);
		chk("pin open", 16'(pinLevel), 16'h0001);
		wr(4'h1, 8'h04);
		w(2);
		chk("inhibit", 16'(ctl.chargeEn), 16'h0000);
		wr(4'h1, 8'h00);
		w(VC + 8);
		chk("inhibit off", 16'(ctl.chargeEn), 16'h0001);
		@(posedge clk) sense.disablePin <= 1'b1;
		w(5);
		chk("disable", 16'(ctl.chargeEn), 16'h0000);
	endtask
	task t_uv;
		int n;
		go_chg();
		@(posedge clk) sense.vbusAboveMin <= 1'b0;
		w(5);
		rc(4'h0, 8'h73);
		chk("uv chargeEn", 16'(ctl.chargeEn), 16'h0000);
		@(posedge clk) sense.vbusAboveMin <= 1'b1;
		wait_pin(n);
		wait_pin(n);
		chk("blink", 16'(n), 16'(BC));
		w(VC - 4);
		chk("retry hold", 16'(ctl.chargeEn), 16'h0000);
		w(RC + VC);
		chk("restart", 16'(ctl.chargeEn), 16'h0001);
	endtask
	task t_sleep;
		go_chg();
		@(posedge clk) sense.vbusBelowSleep <= 1'b1;
		w(5);
		rc(4'h0, 8'h02, 8'h07);
		chk("reverse block", 16'(ctl.reverseBlock), 16'h0001);
		chk("sleep charge", 16'(ctl.chargeEn), 16'h0000);
		@(posedge clk) sense.vbusBelowSleep <= 1'b0;
		w(VC + 8);
		chk("wake charge", 16'(ctl.chargeEn), 16'h0001);
		rc(4'h0, 8'h00, 8'h07);
	endtask
	task t_bstflt;
		rst_dut();
		@(posedge clk) sense.pmidReady <= 1'b0;
		wr(4'h1, 8'h01);
		w(10);
		chk("boost start", 16'(ctl.boostEn), 16'h0001);
		w(10);
		chk("boost fault", 16'({ctl.boostEn, ctl.hiZ}), 16'h0001);
		rc(4'h1, 8'h00);
		rc(4'h0, 8'h02, 8'h07);
		wr(4'h1, 8'h00);
		w(2);
		chk("fault hiz clear", 16'(ctl.hiZ), 16'h0000);
	endtask
	task t_ovp;
		go_chg();
		@(posedge clk) sense <= cmf_sense_t'(15'h6284);
		w(5);
		rc(4'h0, 8'h71);
		chk("switch", 16'(ctl.inputSwitchOn), 16'h0000);
		@(posedge clk) sense <= cmf_sense_t'(15'h5284);
		w(5);
		rc(4'h0, 8'h40);
		chk("revalidate", 16'(ctl.chargeEn), 16'h0000);
		w(VC + 8);
		chk("resume", 16'(ctl.chargeEn), 16'h0001);
	endtask
	task t_therm;
		go_chg();
		@(posedge clk) sense <= cmf_sense_t'(15'h5304);
		w(5);
		rc(4'h0, 8'h05, 8'h07);
		w(30);
		chk("suspend", 16'(ctl.chargeEn), 16'h0000);
		@(posedge clk) sense <= cmf_sense_t'(15'h5284);
		w(5);
		chk("resume", 16'(ctl.chargeEn), 16'h0001);
		rst_dut();
		@(posedge clk) sense.vbusAboveMin <= 1'b1;
		w(10);
		@(posedge clk) sense <= cmf_sense_t'(15'h5304);
		w(30);
		@(posedge clk) sense <= cmf_sense_t'(15'h5284);
		w(3);
		chk("frozen timer", 16'(ctl.chargeEn), 16'h0000);
		w(VC);
		chk("timer resumed", 16'(ctl.chargeEn), 16'h0001);
	endtask
	task t_batovp;
		go_chg();
		@(posedge clk) sense.vbatOver4v8 <= 1'b1;
		w(5);
		rc(4'h0, 8'h74);
		chk("bat ovp", 16'(ctl.chargeEn), 16'h0000);
		chk("no charge mode", 16'(ctl.opMode), 16'(MODE_NOCHG));
		@(posedge clk) sense.vbatOver4v8 <= 1'b0;
		w(5);
		rc(4'h0, 8'h00, 8'h07);
	endtask
	task t_probe(logic bat, logic [7:0] f);
		go_chg();
		@(posedge clk) sense.vbatAbove2v <= bat;
		@(posedge clk) sense.termDetect <= 1'b1;
		w(5);
		rc(4'h0, 8'h20, 8'h30);
		chk("drain", 16'(ctl.probeDrainOn), 16'h0001);
		@(posedge clk) sense.termDetect <= 1'b0;
		w(PC + 5);
		rc(4'h0, f, 8'h07);
		chk("limit500", 16'(ctl.inputLimit500), 16'(!bat));
		chk("nobat charge", 16'(ctl.chargeEn), 16'(!bat));
		@(posedge clk) sense.disablePin <= 1'b1;
		w(5);
		chk("nobat exit", 16'(ctl.inputLimit500), 16'h0000);
	endtask
	task t_mode;
		logic [3:0] tbl [4];
		tbl = '{4'h0, 4'hA, 4'hD, 4'hD};
		rst_dut();
		for (int i = 0; i < 4; i++)
		begin
			wr(4'h1, 8'(i));
			w(2);
			chk("mode", 16'({ctl.opMode, ctl.boostEn, ctl.hiZ}), 16'(tbl[i]));
		end
		@(posedge clk) sense <= cmf_sense_t'(15'h1286);
		wr(4'h1, 8'h01);
		w(5);
		@(posedge clk) sense <= cmf_sense_t'(15'h1287);
		w(5);
		chk("burst off", 16'(ctl.boostPulseAllow), 16'h0000);
		@(posedge clk) sense <= cmf_sense_t'(15'h1285);
		w(5);
		chk("burst on", 16'(ctl.boostPulseAllow), 16'h0001);
	endtask
	task t_host;
		rst_dut();
		wr(4'h6, 8'h03);
		wr(4'h1, 8'h02);
		@(posedge clk) sense.hostPowerPin <= 1'b1;
		w(5);
		chk("host boost", 16'(ctl.boostEn), 16'h0001);
		wr(4'h6, 8'h01);
		w(2);
		chk("pin inactive", 16'(ctl.boostEn), 16'h0000);
		@(posedge clk) sense.hostPowerPin <= 1'b0;
		w(5);
		chk("low active", 16'(ctl.boostEn), 16'h0001);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		rst = 1'b1;
		addr = 4'h0;
		wrData = 8'h00;
		wrStb = 1'b0;
		rdStb = 1'b0;
		sense = SENSE0;
		n_fail = 0;
		total_checks = 0;
		t_regs();
		t_charge();
		t_uv();
		t_sleep();
		t_ovp();
		t_therm();
		t_batovp();
		t_probe(1'b1, 8'h00);
		t_probe(1'b0, 8'h07);
		t_mode();
		t_host();
		t_bstflt();
		end_sim();
	end
	initial
	begin
		#100000;
		n_fail++;
		end_sim();
	end
endmodule
bind cmf_ctrl cmf_ctrl_chk u_chk (.clk(clk), .rst(rst), .addr(addr), .rdStb(rdStb), .rdData(rdData),
	.senseIn(senseIn), .ctl(ctl), .condPinOut(condPinOut));
